// ### hdl/alp_angle_pwm.v
`timescale 1ns/1ps
`include "alp_defs.vh"
module alp_angle_pwm #(
    parameter PER_BASE = 2500,
    parameter PER_STEP = 250,
    parameter ERR_CODE_STEP = 12'h1c0
) (
    input wire pclk,
    input wire presetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire [5:0] nvm_addr,
    input wire [15:0] nvm_rdata,
    output wire init_done,
    input wire [13:0] angle_i,
    input wire angle_valid_i,
    input wire [7:0] err_flags_i,
    input wire logic_self_test_done_i,
    input wire pwm_i,
    output wire pwm_o,
    output wire pwm_oe
);
    localparam ST_INIT = 2'b01;
    localparam ST_RUN = 2'b10;
    localparam PW = 20;

    reg [1:0] st_r;
    reg [5:0] ini_cnt_r;
    reg [9:0] psr_r;
    reg [1:0] lin_r;
    reg [5:0] hys_r;
    reg [7:0] ere_r;
    reg [15:0] wptr_r;
    reg [11:0] coef_r [0:31];
    reg [13:0] hold_r;
    reg dir_r;
    reg first_r;
    reg [2:0] pin_sync_r;
    reg pin_lvl_r;
    reg [PW-1:0] cnt_r;
    reg [PW-1:0] per_r;
    reg [PW-1:0] high_r;
    reg tri_r;
    reg err_r;

    wire running = st_r[1];
    wire [13:0] lin_ang;
    wire lin_vld;
    wire [4:0] seg = angle_i[13:9];
    wire [4:0] seg_nx = seg + 5'd1;

    // coefficient pair around the measured angle, last point wraps to first
    alp_lin_interp u_lin (
        .pclk(pclk),
        .presetn(presetn),
        .angle_i(angle_i),
        .valid_i(angle_valid_i),
        .lin_en(lin_r[`ALP_LIN_EN]),
        .range_scale(lin_r[`ALP_LIN_LS]),
        .coef_lo(coef_r[seg]),
        .coef_hi(coef_r[seg_nx]),
        .angle_o(lin_ang),
        .valid_o(lin_vld)
    );

    // apb decode: zero wait states, unmapped offsets answer with an error
    wire acc = psel & penable;
    wire is_coef = paddr[7];
    wire hit = is_coef | (paddr[7:5] == 3'b000);
    wire wr = acc & pwrite & hit & running;
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;
    assign nvm_addr = ini_cnt_r;
    assign init_done = running;

    // power-up copy from nonvolatile rows, then normal running
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= ST_INIT;
            ini_cnt_r <= 6'h00;
        end else begin
            case (st_r)
                ST_INIT: begin
                    ini_cnt_r <= ini_cnt_r + 6'h01;
                    if (ini_cnt_r == `ALP_NVM_LAST) begin
                        st_r <= ST_RUN;
                    end
                end
                ST_RUN: st_r <= ST_RUN;
                default: st_r <= ST_INIT;
            endcase
        end
    end

    // shadow settings: loaded during init, then writable over apb
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psr_r <= `ALP_PSR_RST;
            lin_r <= `ALP_LIN_RST;
            hys_r <= `ALP_HYS_RST;
            ere_r <= `ALP_ERE_RST;
            wptr_r <= 16'h0000;
        end else if (!running) begin
            if (ini_cnt_r == `ALP_NVM_PSR) psr_r <= nvm_rdata[9:0];
            if (ini_cnt_r == `ALP_NVM_LIN) lin_r <= nvm_rdata[1:0];
            if (ini_cnt_r == `ALP_NVM_HYS) hys_r <= nvm_rdata[5:0];
            if (ini_cnt_r == `ALP_NVM_ERE) ere_r <= nvm_rdata[7:0];
        end else if (wr && !is_coef) begin
            case (paddr)
                `ALP_OFS_PSR: psr_r <= pwdata[9:0];
                `ALP_OFS_LIN: lin_r <= pwdata[1:0];
                `ALP_OFS_HYS: hys_r <= pwdata[5:0];
                `ALP_OFS_ERE: ere_r <= pwdata[7:0];
                `ALP_OFS_WPTR: wptr_r <= pwdata[15:0];
                default: wptr_r <= wptr_r;
            endcase
        end
    end

    // coefficient storage, one entry per 11.25 degree point
    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_coef
            always @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    coef_r[gi] <= 12'h000;
                end else if (!running && ini_cnt_r == gi) begin
                    coef_r[gi] <= nvm_rdata[11:0];
                end else if (wr && is_coef && paddr[6:2] == gi) begin
                    coef_r[gi] <= pwdata[11:0];
                end
            end
        end
    endgenerate

    // hysteresis on the corrected angle, modulo one turn in 14-bit units
    wire [13:0] diff = lin_ang - hold_r;
    wire fwd = dir_r ? diff[13] : ~diff[13];
    wire [13:0] back = dir_r ? diff : (14'h0000 - diff);
    wire moved = diff != 14'h0000;
    wire far_exit = back > {8'h00, hys_r};

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_r <= 14'h0000;
            dir_r <= 1'b0;
            first_r <= 1'b1;
        end else if (logic_self_test_done_i) begin
            dir_r <= 1'b0;
            first_r <= 1'b1;
        end else if (lin_vld) begin
            first_r <= 1'b0;
            if (first_r) begin
                hold_r <= lin_ang;
            end else if (moved && fwd) begin
                hold_r <= lin_ang;
            end else if (moved && far_exit) begin
                hold_r <= lin_ang;
                dir_r <= ~dir_r;
            end
        end
    end

    // pin readback: three stages, level changes once the last two agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_sync_r <= 3'b111;
            pin_lvl_r <= 1'b1;
        end else begin
            pin_sync_r <= {pin_sync_r[1:0], pwm_i};
            if (pin_sync_r[1] == pin_sync_r[2]) begin
                pin_lvl_r <= pin_sync_r[2];
            end
        end
    end

    // error selection: lowest set enabled flag has the highest priority
    wire [7:0] err_m = err_flags_i & ere_r;
    reg [2:0] err_idx;
    integer k;
    always @* begin
        err_idx = 3'd0;
        for (k = 7; k >= 0; k = k - 1) begin
            if (err_m[k]) err_idx = k[2:0];
        end
    end
    wire err_act = psr_r[`ALP_PSR_EOE] & (|err_m);
    wire err_tri = err_act & ~psr_r[`ALP_PSR_ESS];
    wire err_dbl = err_act & psr_r[`ALP_PSR_ESS];

    // next period length from frequency and band select, doubled on error when ALP_PSR_ESS is set
    wire [4:0] frq = psr_r[`ALP_PSR_FRQ_HI:`ALP_PSR_FRQ_LO];
    wire [1:0] bnd = psr_r[`ALP_PSR_BND_HI:`ALP_PSR_BND_LO];
    wire [PW-1:0] per_b = PER_BASE[PW-1:0] + frq * PER_STEP[PW-1:0];
    wire [PW-1:0] per_f = per_b << bnd;
    wire [PW-1:0] per_n = err_dbl ? (per_f << 1) : per_f;

    // high time: fixed lead plus 90% span scaled by the 12-bit code
    wire [11:0] err_code = ({9'h000, err_idx} + 12'h001) * ERR_CODE_STEP;
    wire [11:0] code = err_dbl ? err_code : hold_r[13:2];
    wire [31:0] lead_w = {{(32-PW){1'b0}}, per_n} / `ALP_LEAD_DIV;
    wire [PW-1:0] lead = lead_w[PW-1:0];
    wire [PW-1:0] span = per_n - (lead << 1);
    wire [PW+11:0] scaled = span * code;
    wire [PW-1:0] high_n = lead + scaled[PW+11:`ALP_CODE_BITS];
    // a zero length (first period after init) must wrap at once, not count up to all ones
    wire per_zero = per_r == {PW{1'b0}};
    wire wrap = per_zero | (cnt_r >= per_r - {{(PW-1){1'b0}}, 1'b1});

    // carrier counter: everything for a period except the enable bit is latched at its start
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= {PW{1'b0}};
            per_r <= {PW{1'b0}};
            high_r <= {PW{1'b0}};
            tri_r <= 1'b0;
            err_r <= 1'b0;
        end else if (!running) begin
            cnt_r <= {PW{1'b0}};
        end else if (wrap) begin
            cnt_r <= {PW{1'b0}};
            per_r <= per_n;
            high_r <= high_n;
            tri_r <= err_tri;
            err_r <= err_act;
        end else begin
            cnt_r <= cnt_r + {{(PW-1){1'b0}}, 1'b1};
        end
    end

    // open drain: only ever pulls low during the low part of the period
    wire pwm_on = running & psr_r[`ALP_PSR_EN] & ~tri_r & (per_r != {PW{1'b0}});
    assign pwm_o = 1'b0;
    assign pwm_oe = pwm_on & (cnt_r >= high_r);

    // read data captured in the setup cycle
    wire [31:0] sta = {28'h0, running, pin_lvl_r, err_r, dir_r};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (is_coef) begin
                prdata <= {20'h00000, coef_r[paddr[6:2]]};
            end else begin
                case (paddr)
                    `ALP_OFS_PSR: prdata <= {22'h0, psr_r};
                    `ALP_OFS_LIN: prdata <= {30'h0, lin_r};
                    `ALP_OFS_HYS: prdata <= {26'h0, hys_r};
                    `ALP_OFS_ANG: prdata <= {20'h0, lin_ang[13:2]};
                    `ALP_OFS_HANG: prdata <= {20'h0, hold_r[13:2]};
                    `ALP_OFS_STA: prdata <= sta;
                    `ALP_OFS_ERE: prdata <= {24'h0, ere_r};
                    `ALP_OFS_WPTR: prdata <= {16'h0, wptr_r};
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end
endmodule

// ### include/alp_defs.vh
`ifndef ALP_DEFS_VH
`define ALP_DEFS_VH
// register byte offsets
`define ALP_OFS_PSR 8'h00
`define ALP_OFS_LIN 8'h04
`define ALP_OFS_HYS 8'h08
`define ALP_OFS_ANG 8'h0c
`define ALP_OFS_HANG 8'h10
`define ALP_OFS_STA 8'h14
`define ALP_OFS_ERE 8'h18
`define ALP_OFS_WPTR 8'h1c
`define ALP_OFS_COEF 8'h80
// pulse_settings_row fields
`define ALP_PSR_EN 0
`define ALP_PSR_EOE 1
`define ALP_PSR_ESS 2
`define ALP_PSR_FRQ_LO 3
`define ALP_PSR_FRQ_HI 7
`define ALP_PSR_BND_LO 8
`define ALP_PSR_BND_HI 9
// linearizer control fields
`define ALP_LIN_EN 0
`define ALP_LIN_LS 1
// status fields
`define ALP_ROTATION_DIRECTION_FLAG 0
`define ALP_STA_ERR 1
`define ALP_STA_PIN 2
`define ALP_STA_INIT 3
// reset values of shadows before the copy
`define ALP_PSR_RST 10'h001
`define ALP_LIN_RST 2'h0
`define ALP_HYS_RST 6'h00
`define ALP_ERE_RST 8'h00
// nonvolatile row addresses used by the power-up copy
`define ALP_NVM_PSR 6'h20
`define ALP_NVM_LIN 6'h21
`define ALP_NVM_HYS 6'h22
`define ALP_NVM_ERE 6'h23
`define ALP_NVM_LAST 6'h23
// duty clamp: lead and tail are one twentieth of a period each
`define ALP_LEAD_DIV 20
`define ALP_CODE_BITS 12
`endif

// ### hdl/alp_lin_interp.v
`timescale 1ns/1ps
`include "alp_defs.vh"
module alp_lin_interp (
    input wire pclk,
    input wire presetn,
    input wire [13:0] angle_i,
    input wire valid_i,
    input wire lin_en,
    input wire range_scale,
    input wire [11:0] coef_lo,
    input wire [11:0] coef_hi,
    output reg [13:0] angle_o,
    output reg valid_o
);
    wire signed [12:0] c0 = {coef_lo[11], coef_lo};
    wire signed [12:0] c1 = {coef_hi[11], coef_hi};
    wire signed [12:0] dlt = c1 - c0;
    wire signed [9:0] frac = {1'b0, angle_i[8:0]};
    wire signed [22:0] prod = dlt * frac;
    wire signed [13:0] corr = {c0[12], c0} + prod[22:9];
    // scale 0 maps full coefficient range to half the 14-bit span of scale 1
    wire signed [13:0] corr_s = range_scale ? corr : (corr >>> 1);
    wire [13:0] fixed = angle_i - corr_s;

    // one register stage either way so latency never depends on enable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            angle_o <= 14'h0000;
            valid_o <= 1'b0;
        end else begin
            valid_o <= valid_i;
            if (valid_i) begin
                angle_o <= lin_en ? fixed : angle_i;
            end
        end
    end
endmodule

// ### test/alp_host_model.sv
`timescale 1ns/1ps
module alp_host_model (
    input wire pclk,
    input wire pwm_oe,
    output wire pin,
    output integer hi_n,
    output integer per_n
);
    integer hc;
    integer pc;
    reg last;
    initial begin
        hc = 0;
        pc = 0;
        hi_n = 0;
        per_n = 0;
        last = 1'b1;
    end
    // pull-up on the line: a released pin reads high
    assign pin = pwm_oe ? 1'b0 : 1'b1;
    // a period is measured from one rising pin edge to the next
    always @(posedge pclk) begin
        last <= pin;
        if (pin && !last) begin
            per_n <= pc;
            hi_n <= hc;
            pc <= 1;
            hc <= 1;
        end else begin
            pc <= pc + 1;
            hc <= hc + pin;
        end
    end
endmodule

// ### test/alp_angle_pwm_sva.sv
`timescale 1ns/1ps
module alp_angle_pwm_sva (
    input wire pclk,
    input wire presetn,
    input wire [7:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pslverr,
    input wire [5:0] nvm_addr,
    input wire init_done,
    input wire pwm_o,
    input wire pwm_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // lead and tail last at least two cycles
    sequence s_rel2;
        !pwm_oe ##1 !pwm_oe;
    endsequence
    sequence s_pull2;
        pwm_oe ##1 pwm_oe;
    endsequence
    AST_LEAD: assert property ($fell(pwm_oe) |-> s_rel2) else $error("lead short");
    AST_TAIL: assert property ($rose(pwm_oe) |-> s_pull2) else $error("tail short");
    AST_OD: assert property (pwm_o == 1'b0) else $error("pin driven high");
    AST_QUIET: assert property (!init_done |-> !pwm_oe) else $error("pulled in init");
    AST_KEEP: assert property (init_done |=> init_done) else $error("init dropped");
    AST_ROW: assert property (!init_done && nvm_addr != 6'h23 |=>
        init_done || nvm_addr == $past(nvm_addr) + 6'h01) else $error("row skip");
    AST_ROWMAX: assert property (!init_done |-> nvm_addr <= 6'h23) else $error("row high");
    AST_SLV: assert property (pslverr == (psel && penable && paddr >= 8'h20 &&
        paddr < 8'h80)) else $error("slverr wrong");
    AST_RDH: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
endmodule
bind alp_angle_pwm alp_angle_pwm_sva i_sva (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pslverr(pslverr), .nvm_addr(nvm_addr), .init_done(init_done), .pwm_o(pwm_o),
    .pwm_oe(pwm_oe));

// ### test/angle_linearize_pwm_output_test.sv
`timescale 1ns/1ps
module angle_linearize_pwm_output_test;
    reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0, rd;
    reg [13:0] angle_i = 14'h0;
    reg angle_valid_i = 1'b0, logic_self_test_done_i = 1'b0, er;
    reg [7:0] err_flags_i = 8'h00;
    reg [15:0] nvm [0:35];
    wire [31:0] prdata;
    wire pready, pslverr, init_done, pin, pwm_o, pwm_oe;
    wire [5:0] nvm_addr;
    wire [15:0] nvm_rdata = nvm[nvm_addr];
    integer errors = 0, cmp_count = 0, seed = 40491, cyc = 0, hi_n, per_n;
    integer i, n, t, a, p, ld, s, c0, c1, c, held, dir, fw, d, w;
    alp_angle_pwm #(.PER_BASE(40), .PER_STEP(4), .ERR_CODE_STEP(12'h1c0)) i_dut (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .nvm_addr(nvm_addr), .nvm_rdata(nvm_rdata),
        .init_done(init_done), .angle_i(angle_i), .angle_valid_i(angle_valid_i),
        .err_flags_i(err_flags_i), .logic_self_test_done_i(logic_self_test_done_i), .pwm_i(pin),
        .pwm_o(pwm_o), .pwm_oe(pwm_oe));
    alp_host_model i_host (.pclk(pclk), .pwm_oe(pwm_oe), .pin(pin), .hi_n(hi_n),
        .per_n(per_n));
    // clock and run limit
    always #2 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors = errors + 1;
            conclude;
        end
    end
    task conclude;
        begin
            $display("checks %0d mismatches %0d", cmp_count, errors);
            if (errors == 0 && cmp_count > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask
    task check(input [31:0] seen, input [31:0] want, input [63:0] what);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== want) begin
                errors = errors + 1;
                $display("FAIL %0s expected %h seen %h", what, want, seen);
            end
        end
    endtask
    // one apb transfer, held until pready is seen high or 50 wait cycles pass
    task apb(input wr, input [7:0] ad, input [31:0] wd);
        begin
            @(posedge pclk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= ad;
            pwdata <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1 && n < 50) begin
                n = n + 1;
                @(posedge pclk);
            end
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task ang(input [13:0] v);
        begin
            @(posedge pclk);
            angle_i <= v;
            angle_valid_i <= 1'b1;
            @(posedge pclk);
            angle_valid_i <= 1'b0;
            repeat (3) @(posedge pclk);
        end
    endtask
    // period length and high time against the host's measurement
    task pwm_chk(input integer pr, input integer code);
        begin
            repeat (4 * pr + 10) @(posedge pclk);
            ld = pr / 20;
            check(per_n, pr, "period");
            check(hi_n, ld + (((pr - 2 * ld) * code) >> 12), "high");
        end
    endtask
    initial begin
        for (i = 0; i < 36; i = i + 1) begin
            t = $random(seed);
            nvm[i] = {4'h0, t[11:0]};
        end
        nvm[32] = 16'h0011;
        nvm[33] = 16'h0000;
        nvm[34] = 16'h0004;
        nvm[35] = 16'h0000;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        while (init_done !== 1'b1) @(posedge pclk);
        apb(0, 8'h00, 0);
        check(rd, 32'h11, "psr");
        apb(0, 8'h08, 0);
        check(rd, 32'h4, "hyst");
        apb(0, 8'h1c, 0);
        check(rd, 32'h0, "wptr");
        apb(0, 8'h14, 0);
        check(rd & 32'h9, 32'h8, "status");
        for (i = 0; i < 32; i = i + 1) begin
            apb(0, 8'h80 + 4 * i, 0);
            check(rd, nvm[i], "coef");
        end
        apb(0, 8'h40, 0);
        check(er, 1'b1, "unmapped");
        nvm[5] = 16'h0abc;
        apb(1, 8'h94, 32'hcabc);
        apb(0, 8'h94, 0);
        check(rd, 32'habc, "storage");
        $display("test init done");
        // zero window: the held angle follows every new angle in the carrier test
        apb(1, 8'h08, 0);
        for (i = 0; i < 4; i = i + 1) begin
            t = $random(seed);
            a = (i == 0) ? 0 : (i == 3) ? 16383 : t[13:0];
            t = $random(seed);
            apb(1, 8'h00, 1 | (t[4:0] << 3) | (i << 8));
            ang(a);
            pwm_chk((40 + t[4:0] * 4) << i, a >> 2);
        end
        apb(1, 8'h00, 32'h11);
        $display("test carrier done");
        for (i = 0; i < 8; i = i + 1) begin
            s = i % 2;
            t = $random(seed);
            a = t[13:0];
            apb(1, 8'h04, (i < 6) | (s << 1));
            ang(a);
            c0 = $signed(nvm[a >> 9][11:0]);
            c1 = $signed(nvm[((a >> 9) + 1) % 32][11:0]);
            c = c0 + (((c1 - c0) * (a % 512)) >>> 9);
            if (s == 0) c = c >>> 1;
            if (i >= 6) c = 0;
            apb(0, 8'h0c, 0);
            check(rd, ((a - c) & 16383) >> 2, "corr");
        end
        apb(1, 8'h04, 0);
        $display("test correction done");
        w = 4;
        apb(1, 8'h08, w);
        @(posedge pclk);
        logic_self_test_done_i <= 1'b1;
        @(posedge pclk);
        logic_self_test_done_i <= 1'b0;
        apb(0, 8'h14, 0);
        check(rd & 1, 0, "dir");
        dir = 0;
        for (i = 0; i < 40; i = i + 1) begin
            if (i == 20) w = 0;
            if (i == 20) apb(1, 8'h08, 0);
            t = $random(seed);
            a = (a + t % 8) & 16383;
            ang(a);
            d = (a - held) & 16383;
            if (d >= 8192) d = d - 16384;
            fw = dir ? (d < 0) : (d > 0);
            if (i == 0 || fw) held = a;
            else if (d > w || -d > w) begin
                held = a;
                dir = 1 - dir;
            end
            apb(0, 8'h10, 0);
            check(rd, held >> 2, "held");
            apb(0, 8'h14, 0);
            check(rd & 1, dir, "dir");
        end
        $display("test window done");
        apb(1, 8'h18, 32'h6);
        err_flags_i <= 8'h07;
        apb(1, 8'h00, 32'h17);
        pwm_chk(96, 2 * 448);
        err_flags_i <= 8'h01;
        pwm_chk(48, held >> 2);
        err_flags_i <= 8'h04;
        apb(1, 8'h00, 32'h13);
        repeat (150) @(posedge pclk);
        p = 0;
        for (i = 0; i < 200; i = i + 1) begin
            @(posedge pclk);
            p = p + pwm_oe;
        end
        check(p, 0, "tristate");
        apb(1, 8'h00, 32'h11);
        pwm_chk(48, held >> 2);
        $display("test errors done");
        conclude;
    end
endmodule
